// *** peripheral_irq_flag_regs.sv ***
// Peripheral interrupt request flag registers with an APB slave port.
//
// Summary of operation
// - Serial receive flag bits mirror receive buffer full; read-only, cleared by reading buffer.
// - Serial transmit flag bits mirror transmit buffer empty; read-only, cleared by writing buffer.
// - Parallel port flag sets after an external read or write of that port.
// - Converter flag sets on conversion complete and stays until software clears it.
// - Synchronous port flags set on transfer complete; software clears them.
// - Timer 1 gate flag sets on gate event; only software clears it.
// - Timer 2 flag sets on period match; only software clears it.
// - Timer 1 overflow flag sets on overflow; only software clears it.
// - Oscillator fail flag sets when clock falls back to internal oscillator.
// - Bus collision flags set on collision of the matching synchronous port.
// - Voltage detect flag sets when supply drops below trip point.
// - Timer 3 overflow and gate flags set on their events; software clears.
// - Timer 5 gate flag sets on gate event; only software clears it.
// - Bit 6 of second and third registers is absent and reads zero.
// - Charge time and calendar clock flags set on their events; software clears.
// - In capture mode a unit's flag sets when a capture occurs.
// - In compare mode a unit's flag sets on a compare match.
// - In pulse-width mode a unit's flag signals nothing.
// - Fourth register holds units 10 to 4 in bits 7..1, unit 3 bit 0.
// - Small program memory variant omits flags of units 10 and 9.
// - Every implemented flag bit clears to zero at power-on reset.
// - Flags set regardless of any enable, so software may poll them.
`timescale 1ns/100ps
`include "periph_irq_flag_params.svh"
`default_nettype none

module peripheral_irq_flag_regs #(
	parameter bit SMALL_MEMORY = 1'b0
) (
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [11:0]                          paddr,
	input  wire logic [31:0]                          pwdata,
	output logic      [31:0]                          prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	input  wire periph_irq_flag_pkg::periph_events_s  events,
	input  wire periph_irq_flag_pkg::serial_levels_s  serial_levels,
	input  wire logic [`CAPCMP_UNITS:1]               capcmp_capture,
	input  wire logic [`CAPCMP_UNITS:1]               capcmp_match,
	input  wire periph_irq_flag_pkg::capcmp_mode_e    capcmp_mode [`CAPCMP_UNITS:1],
	output periph_irq_flag_pkg::flag_bank_s           flags
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Next value of one sticky register: a write replaces writable bits, then any
	// hardware set is OR-ed in last so that a set in the clearing cycle survives.
	function automatic logic [7:0] flag_next(
		input logic [7:0] cur,
		input logic       wr,
		input logic [7:0] wdata,
		input logic [7:0] set,
		input logic [7:0] rw_mask
	);
		logic [7:0] held;
		held = wr ? (wdata & rw_mask) : (cur & rw_mask);
		return held | (set & rw_mask);
	endfunction

	// Decode of a single register address, used in both the setup and the access phase.
	function automatic logic addr_is(
		input logic [11:0] addr,
		input logic [11:0] offset
	);
		return addr == offset;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	logic       access;
	logic       setup;
	logic       hit_a;
	logic       hit_b;
	logic       hit_c;
	logic       hit_d;
	logic       mapped;
	logic       wr_a;
	logic       wr_b;
	logic       wr_c;
	logic       wr_d;
	logic [7:0] wbyte;
	logic [7:0] rw_mask_d;

	// Zero wait states: every access finishes in its first access cycle.
	assign access    = psel & penable;
	assign setup     = psel & ~penable;
	assign pready    = 1'b1;
	assign wbyte     = pwdata[7:0];
	assign rw_mask_d = SMALL_MEMORY ? `RW_MASK_D_SMALL : `RW_MASK_D;

	// Address decode; anything outside the four words is refused with an error.
	always_comb begin
		hit_a = 1'b0;
		hit_b = 1'b0;
		hit_c = 1'b0;
		hit_d = 1'b0;
		if (addr_is(paddr, `OFF_FLAGS_A)) begin
			hit_a = 1'b1;
		end else if (addr_is(paddr, `OFF_FLAGS_B)) begin
			hit_b = 1'b1;
		end else if (addr_is(paddr, `OFF_FLAGS_C)) begin
			hit_c = 1'b1;
		end else if (addr_is(paddr, `OFF_FLAGS_D)) begin
			hit_d = 1'b1;
		end
	end

	// Writes take effect only at the access edge, never in the setup cycle.
	assign mapped  = hit_a | hit_b | hit_c | hit_d;
	assign pslverr = access & ~mapped;
	assign wr_a    = access & pwrite & hit_a;
	assign wr_b    = access & pwrite & hit_b;
	assign wr_c    = access & pwrite & hit_c;
	assign wr_d    = access & pwrite & hit_d;

	////////////////////////////////////////////////////////////////////////////////
	// Hardware set sources.

	logic [7:0]               set_a;
	logic [7:0]               set_b;
	logic [7:0]               set_c;
	logic [7:0]               set_d;
	logic [`CAPCMP_UNITS:1]   capcmp_set;

	// A unit raises its flag only for the event that its mode gives meaning to;
	// pulse-width and idle units never raise it.
	always_comb begin
		for (int u = 1; u <= `CAPCMP_UNITS; u++) begin
			capcmp_set[u] =
				((capcmp_mode[u] == periph_irq_flag_pkg::CAPCMP_CAPTURE) & capcmp_capture[u]) |
				((capcmp_mode[u] == periph_irq_flag_pkg::CAPCMP_COMPARE) & capcmp_match[u]);
		end
	end

	// First register sources; enables are not looked at, so polling works.
	always_comb begin
		set_a                        = 8'h00;
		set_a[`BIT_PARALLEL_PORT]    = events.parallel_port;
		set_a[`BIT_CONVERTER_DONE]   = events.converter_done;
		set_a[`BIT_SYNC_PORT1]       = events.sync_port1;
		set_a[`BIT_TIMER1_GATE]      = events.timer1_gate;
		set_a[`BIT_TIMER2_MATCH]     = events.timer2_match;
		set_a[`BIT_TIMER1_OVERFLOW]  = events.timer1_overflow;
	end

	// Second register sources.
	always_comb begin
		set_b                        = 8'h00;
		set_b[`BIT_OSC_FAIL]         = events.osc_fail;
		set_b[`BIT_SYNC_PORT2]       = events.sync_port2;
		set_b[`BIT_COLLISION2]       = events.collision2;
		set_b[`BIT_COLLISION1]       = events.collision1;
		set_b[`BIT_VOLTAGE_DETECT]   = events.voltage_detect;
		set_b[`BIT_TIMER3_OVERFLOW]  = events.timer3_overflow;
		set_b[`BIT_TIMER3_GATE]      = events.timer3_gate;
	end

	// Third register sources.
	always_comb begin
		set_c                        = 8'h00;
		set_c[`BIT_TIMER5_GATE]      = events.timer5_gate;
		set_c[`BIT_CHARGE_TIME]      = events.charge_time;
		set_c[`BIT_CAPCMP2]          = capcmp_set[2];
		set_c[`BIT_CAPCMP1]          = capcmp_set[1];
		set_c[`BIT_CALENDAR_CLOCK]   = events.calendar_clock;
	end

	// Units 3 to 10 fill the fourth register from bit 0 upward.
	assign set_d = capcmp_set[`CAPCMP_UNITS:`CAPCMP_LOW_IN_D];

	////////////////////////////////////////////////////////////////////////////////
	// Flag registers.

	logic [7:0] flags_a_r;
	logic [7:0] flags_b_r;
	logic [7:0] flags_c_r;
	logic [7:0] flags_d_r;
	logic [7:0] flags_a_nxt;
	logic [7:0] flags_b_nxt;
	logic [7:0] flags_c_nxt;
	logic [7:0] flags_d_nxt;
	logic [7:0] serial_a_r;
	logic [7:0] serial_c_r;

	// Sticky next values; the masks keep absent bits at zero for good.
	assign flags_a_nxt = flag_next(flags_a_r, wr_a, wbyte, set_a, `RW_MASK_A);
	assign flags_b_nxt = flag_next(flags_b_r, wr_b, wbyte, set_b, `RW_MASK_B);
	assign flags_c_nxt = flag_next(flags_c_r, wr_c, wbyte, set_c, `RW_MASK_C);
	assign flags_d_nxt = flag_next(flags_d_r, wr_d, wbyte, set_d, rw_mask_d);

	// First register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_a_r <= `FLAGS_RESET;
		end else begin
			flags_a_r <= flags_a_nxt;
		end
	end

	// Second register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_b_r <= `FLAGS_RESET;
		end else begin
			flags_b_r <= flags_b_nxt;
		end
	end

	// Third register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_c_r <= `FLAGS_RESET;
		end else begin
			flags_c_r <= flags_c_nxt;
		end
	end

	// Fourth register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_d_r <= `FLAGS_RESET;
		end else begin
			flags_d_r <= flags_d_nxt;
		end
	end

	// Serial buffer flags are not sticky: they follow the channel's buffer level,
	// so the channel clears them by its own buffer access and writes cannot.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_a_r <= `FLAGS_RESET;
			serial_c_r <= `FLAGS_RESET;
		end else begin
			serial_a_r                 <= `FLAGS_RESET;
			serial_c_r                 <= `FLAGS_RESET;
			serial_a_r[`BIT_SERIAL_RX] <= serial_levels.serial1_rx_full;
			serial_a_r[`BIT_SERIAL_TX] <= serial_levels.serial1_tx_empty;
			serial_c_r[`BIT_SERIAL_RX] <= serial_levels.serial2_rx_full;
			serial_c_r[`BIT_SERIAL_TX] <= serial_levels.serial2_tx_empty;
		end
	end

	// Full view of each register for the bus and the priority logic.
	assign flags.periph_flags_a = flags_a_r | serial_a_r;
	assign flags.periph_flags_b = flags_b_r;
	assign flags.periph_flags_c = flags_c_r | serial_c_r;
	assign flags.periph_flags_d = flags_d_r;

	////////////////////////////////////////////////////////////////////////////////
	// Read data.

	// Read data is captured in the setup cycle so that prdata comes from a flop
	// and is steady through the access cycle; unmapped reads return zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			if (hit_a) begin
				prdata <= {24'h00_0000, flags.periph_flags_a};
			end else if (hit_b) begin
				prdata <= {24'h00_0000, flags.periph_flags_b};
			end else if (hit_c) begin
				prdata <= {24'h00_0000, flags.periph_flags_c};
			end else if (hit_d) begin
				prdata <= {24'h00_0000, flags.periph_flags_d};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking chk_clk @(posedge pclk);
	endclocking

	default disable iff (!presetn);

	// A conversion event is flagged on the next edge even if cleared at once.
	chk_converter_sticky: assert property (
		events.converter_done |=> flags.periph_flags_a[`BIT_CONVERTER_DONE]
	) else $error("converter flag not raised by its event");

	// An event coinciding with a clearing write still leaves the flag set.
	chk_set_beats_clear: assert property (
		(wr_b && !pwdata[`BIT_OSC_FAIL] && events.osc_fail)
			|=> flags.periph_flags_b[`BIT_OSC_FAIL]
	) else $error("set lost against a clearing write");

	// Timer 1 overflow stays set until software writes the first register.
	chk_overflow_holds: assert property (
		(flags.periph_flags_a[`BIT_TIMER1_OVERFLOW] && !wr_a)
			|=> flags.periph_flags_a[`BIT_TIMER1_OVERFLOW]
	) else $error("overflow flag dropped without a write");

	// Receive flag follows the channel 1 buffer level one cycle later.
	chk_rx_follows: assert property (
		##1 flags.periph_flags_a[`BIT_SERIAL_RX] == $past(serial_levels.serial1_rx_full)
	) else $error("receive flag does not follow buffer full");

	// Transmit flag of channel 2 ignores writes and tracks the buffer level.
	chk_tx_readonly: assert property (
		(wr_c && !serial_levels.serial2_tx_empty)
			|=> !flags.periph_flags_c[`BIT_SERIAL_TX]
	) else $error("transmit flag altered by a write");

	// Absent bits of the second and third registers never show a one.
	chk_absent_zero: assert property (
		!flags.periph_flags_b[`BIT_B_ABSENT] && !flags.periph_flags_c[`BIT_C_ABSENT]
	) else $error("unimplemented bit reads one");

	// A pulse-width unit never raises a clear flag, whatever its inputs do.
	chk_pwm_silent: assert property (
		(capcmp_mode[1] == periph_irq_flag_pkg::CAPCMP_PWM && !wr_c
			&& !flags.periph_flags_c[`BIT_CAPCMP1])
			|=> !flags.periph_flags_c[`BIT_CAPCMP1]
	) else $error("pulse-width unit raised its flag");

	// A compare match on unit 3 lands in bit 0 of the fourth register.
	chk_unit3_position: assert property (
		(capcmp_mode[3] == periph_irq_flag_pkg::CAPCMP_COMPARE && capcmp_match[3])
			|=> flags.periph_flags_d[0]
	) else $error("unit 3 compare match not flagged at bit 0");

	// A quiet write stores exactly the writable part of the data.
	chk_write_stores: assert property (
		(wr_b && set_b == 8'h00) |=> flags.periph_flags_b == ($past(wbyte) & `RW_MASK_B)
	) else $error("written value not stored");

	// The small variant never shows the top two unit flags.
	chk_small_variant: assert property (
		SMALL_MEMORY |-> flags.periph_flags_d[7:6] == 2'b00
	) else $error("absent unit flags implemented");

	// A read returns in the access cycle the value sampled at setup.
	chk_read_data: assert property (
		(setup && !pwrite && hit_a) |=> prdata[7:0] == $past(flags.periph_flags_a)
	) else $error("read data does not match register");

endmodule

`default_nettype wire

// *** periph_irq_flag_params.svh ***
// Offsets, bit positions, masks and reset values of the peripheral flag registers.
`ifndef PERIPH_IRQ_FLAG_PARAMS_SVH
`define PERIPH_IRQ_FLAG_PARAMS_SVH

// Register byte addresses on the APB (word aligned, low 12 address bits decoded).
`define OFF_FLAGS_A          12'h000
`define OFF_FLAGS_B          12'h004
`define OFF_FLAGS_C          12'h008
`define OFF_FLAGS_D          12'h00C

// Power-on value of every flag register.
`define FLAGS_RESET          8'h00

// Bits that software may write in each register; the rest are read-only or absent.
`define RW_MASK_A            8'hCF
`define RW_MASK_B            8'hBF
`define RW_MASK_C            8'h8F
`define RW_MASK_D            8'hFF
`define RW_MASK_D_SMALL      8'h3F

// Bit positions in the first flag register.
`define BIT_PARALLEL_PORT    7
`define BIT_CONVERTER_DONE   6
`define BIT_SERIAL_RX        5
`define BIT_SERIAL_TX        4
`define BIT_SYNC_PORT1       3
`define BIT_TIMER1_GATE      2
`define BIT_TIMER2_MATCH     1
`define BIT_TIMER1_OVERFLOW  0

// Bit positions in the second flag register.
`define BIT_OSC_FAIL         7
`define BIT_B_ABSENT         6
`define BIT_SYNC_PORT2       5
`define BIT_COLLISION2       4
`define BIT_COLLISION1       3
`define BIT_VOLTAGE_DETECT   2
`define BIT_TIMER3_OVERFLOW  1
`define BIT_TIMER3_GATE      0

// Bit positions in the third flag register (serial 2 uses the same rx/tx bits as serial 1).
`define BIT_TIMER5_GATE      7
`define BIT_C_ABSENT         6
`define BIT_CHARGE_TIME      3
`define BIT_CAPCMP2          2
`define BIT_CAPCMP1          1
`define BIT_CALENDAR_CLOCK   0

// Capture/compare unit numbering and the fourth register layout.
`define CAPCMP_UNITS         10
`define CAPCMP_LOW_IN_D      3

`endif

// *** periph_irq_flag_pkg.sv ***
// Types shared by the peripheral flag registers and their surroundings.
`default_nettype none

package periph_irq_flag_pkg;

	// Operating mode of one capture/compare unit.
	typedef enum logic [1:0] {
		CAPCMP_CAPTURE = 2'b00,
		CAPCMP_COMPARE = 2'b01,
		CAPCMP_PWM     = 2'b10,
		CAPCMP_OFF     = 2'b11
	} capcmp_mode_e;

	// One-cycle event pulses from the peripherals that own a sticky flag.
	typedef struct packed {
		logic parallel_port;
		logic converter_done;
		logic sync_port1;
		logic timer1_gate;
		logic timer2_match;
		logic timer1_overflow;
		logic osc_fail;
		logic sync_port2;
		logic collision2;
		logic collision1;
		logic voltage_detect;
		logic timer3_overflow;
		logic timer3_gate;
		logic timer5_gate;
		logic charge_time;
		logic calendar_clock;
	} periph_events_s;

	// Buffer state levels of the two asynchronous serial channels.
	typedef struct packed {
		logic serial1_rx_full;
		logic serial1_tx_empty;
		logic serial2_rx_full;
		logic serial2_tx_empty;
	} serial_levels_s;

	// The four flag registers as seen by the interrupt priority logic.
	typedef struct packed {
		logic [7:0] periph_flags_d;
		logic [7:0] periph_flags_c;
		logic [7:0] periph_flags_b;
		logic [7:0] periph_flags_a;
	} flag_bank_s;

endpackage

`default_nettype wire

// *** periph_event_model.sv ***
// Behavioural model of the peripherals that raise flag events and drive serial buffer levels.
`timescale 1ns/100ps
`include "periph_irq_flag_params.svh"
`default_nettype none

module periph_event_model (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic [3:0]                     density,
	output periph_irq_flag_pkg::periph_events_s events,
	output periph_irq_flag_pkg::serial_levels_s serial_levels,
	output logic [`CAPCMP_UNITS:1]              capcmp_capture,
	output logic [`CAPCMP_UNITS:1]              capcmp_match,
	output periph_irq_flag_pkg::capcmp_mode_e   capcmp_mode [`CAPCMP_UNITS:1]
);
	int                            seed;
	logic [15:0]                   ev;
	logic [3:0]                    lv;
	logic [`CAPCMP_UNITS:1]        cap;
	logic [`CAPCMP_UNITS:1]        mat;

	////////////////////////////////////////////////////////////////////////////////
	// Each source pulses with a chance of density in eight; a density of 8 pulses always.
	// Buffer levels toggle rarely, so they hold for many cycles as a real channel would.
	initial seed = 32'h6039_305b;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			events <= '0;
			serial_levels <= '0;
			capcmp_capture <= '0;
			capcmp_match <= '0;
			for (int u = 1; u <= `CAPCMP_UNITS; u++) capcmp_mode[u] <= periph_irq_flag_pkg::CAPCMP_CAPTURE;
		end else begin
			for (int i = 0; i < 16; i++) ev[i] = ($random(seed) & 7) < density;
			lv = serial_levels;
			for (int j = 0; j < 4; j++) if (($random(seed) & 15) == 0) lv[j] = ~lv[j];
			for (int u = 1; u <= `CAPCMP_UNITS; u++) begin
				cap[u] = ($random(seed) & 7) < density;
				mat[u] = ($random(seed) & 7) < density;
				if (($random(seed) & 31) == 0)
					capcmp_mode[u] <= periph_irq_flag_pkg::capcmp_mode_e'(2'($random(seed)));
			end
			events <= periph_irq_flag_pkg::periph_events_s'(ev);
			serial_levels <= periph_irq_flag_pkg::serial_levels_s'(lv);
			capcmp_capture <= cap;
			capcmp_match <= mat;
		end
	end
endmodule

`default_nettype wire

// *** peripheral_irq_flag_regs_tb.sv ***
// Self-checking testbench of the peripheral flag registers, with a cycle reference model.
`timescale 1ns/100ps
`include "periph_irq_flag_params.svh"
`default_nettype none

module peripheral_irq_flag_regs_tb;
	logic                                pclk;
	logic                                presetn;
	logic                                psel;
	logic                                penable;
	logic                                pwrite;
	logic [11:0]                         paddr;
	logic [31:0]                         pwdata;
	logic [31:0]                         prdata;
	logic                                pready;
	logic                                pslverr;
	logic [3:0]                          density;
	periph_irq_flag_pkg::periph_events_s events;
	periph_irq_flag_pkg::serial_levels_s serial_levels;
	logic [`CAPCMP_UNITS:1]              capcmp_capture;
	logic [`CAPCMP_UNITS:1]              capcmp_match;
	periph_irq_flag_pkg::capcmp_mode_e   capcmp_mode [`CAPCMP_UNITS:1];
	periph_irq_flag_pkg::flag_bank_s     flags;
	periph_irq_flag_pkg::flag_bank_s     flags_small;
	periph_irq_flag_pkg::flag_bank_s     exp_q;
	periph_irq_flag_pkg::flag_bank_s     snap;
	int                                  num_errors;
	int                                  num_checks;
	int                                  cycles;
	int                                  seed;
	logic [31:0]                         r;
	logic [31:0]                         rd;
	logic                                err;

	////////////////////////////////////////////////////////////////////////////////
	// The full variant is checked through its bus; the small one shares all inputs.
	peripheral_irq_flag_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .events(events), .serial_levels(serial_levels),
		.capcmp_capture(capcmp_capture), .capcmp_match(capcmp_match),
		.capcmp_mode(capcmp_mode), .flags(flags));
	peripheral_irq_flag_regs #(.SMALL_MEMORY(1'b1)) dut_small (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(), .pready(), .pslverr(), .events(events), .serial_levels(serial_levels),
		.capcmp_capture(capcmp_capture), .capcmp_match(capcmp_match),
		.capcmp_mode(capcmp_mode), .flags(flags_small));
	periph_event_model partner (.pclk(pclk), .presetn(presetn), .density(density),
		.events(events), .serial_levels(serial_levels), .capcmp_capture(capcmp_capture),
		.capcmp_match(capcmp_match), .capcmp_mode(capcmp_mode));

	////////////////////////////////////////////////////////////////////////////////
	// A write replaces the writable bits, and any event of the same cycle still sets its bit.
	function automatic logic [7:0] upd(input logic [7:0] cur, input logic hit,
		input logic [7:0] wd, input logic [7:0] set, input logic [7:0] mask);
		upd = ((hit ? wd : cur) & mask) | set;
	endfunction

	// Next state of the whole bank from the inputs seen at a rising edge.
	function automatic periph_irq_flag_pkg::flag_bank_s next_flags(
		input periph_irq_flag_pkg::flag_bank_s cur);
		logic [`CAPCMP_UNITS:1]              cc;
		logic                                wr;
		periph_irq_flag_pkg::periph_events_s e;
		periph_irq_flag_pkg::serial_levels_s s;
		periph_irq_flag_pkg::flag_bank_s     nf;
		wr = psel && penable && pwrite;
		e = events;
		s = serial_levels;
		for (int u = 1; u <= `CAPCMP_UNITS; u++) begin
			cc[u] = (capcmp_mode[u] == periph_irq_flag_pkg::CAPCMP_CAPTURE && capcmp_capture[u])
				|| (capcmp_mode[u] == periph_irq_flag_pkg::CAPCMP_COMPARE && capcmp_match[u]);
		end
		nf.periph_flags_a = upd(cur.periph_flags_a, wr && paddr == `OFF_FLAGS_A, pwdata[7:0],
			{e.parallel_port, e.converter_done, 2'b00, e.sync_port1, e.timer1_gate,
			e.timer2_match, e.timer1_overflow}, `RW_MASK_A)
			| {2'b00, s.serial1_rx_full, s.serial1_tx_empty, 4'h0};
		nf.periph_flags_b = upd(cur.periph_flags_b, wr && paddr == `OFF_FLAGS_B, pwdata[7:0],
			{e.osc_fail, 1'b0, e.sync_port2, e.collision2, e.collision1, e.voltage_detect,
			e.timer3_overflow, e.timer3_gate}, `RW_MASK_B);
		nf.periph_flags_c = upd(cur.periph_flags_c, wr && paddr == `OFF_FLAGS_C, pwdata[7:0],
			{e.timer5_gate, 3'b000, e.charge_time, cc[2], cc[1], e.calendar_clock}, `RW_MASK_C)
			| {2'b00, s.serial2_rx_full, s.serial2_tx_empty, 4'h0};
		nf.periph_flags_d = upd(cur.periph_flags_d, wr && paddr == `OFF_FLAGS_D, pwdata[7:0],
			cc[`CAPCMP_UNITS:3], `RW_MASK_D);
		next_flags = nf;
	endfunction

	// Read data is the register value at the setup edge; unmapped words read zero.
	function automatic logic [31:0] exp_read(input logic [11:0] a);
		case (a)
			`OFF_FLAGS_A: exp_read = 32'(snap.periph_flags_a);
			`OFF_FLAGS_B: exp_read = 32'(snap.periph_flags_b);
			`OFF_FLAGS_C: exp_read = 32'(snap.periph_flags_c);
			`OFF_FLAGS_D: exp_read = 32'(snap.periph_flags_d);
			default: exp_read = 32'h0000_0000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One APB transfer, entered just after a rising edge; the caller decides on release.
	// The wait for pready has no limit of its own: only the bench timeout ends a hang.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		snap = exp_q;
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		check_word("pslverr", 32'(!(a inside {`OFF_FLAGS_A, `OFF_FLAGS_B, `OFF_FLAGS_C,
			`OFF_FLAGS_D})), 32'(err));
		if (!wr) check_word("prdata", exp_read(a), rd);
	endtask

	task automatic apb_idle();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reference model and the per-cycle comparison of both variants.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) exp_q <= '0;
		else exp_q <= next_flags(exp_q);
	end

	always @(negedge pclk) begin
		if (presetn === 1'b1) begin
			check_word("flags", exp_q, flags);
			check_word("flags_small", {2'b00, exp_q[29:0]}, flags_small);
		end
	end

	// The ceiling is far above the fewer than two thousand cycles the tests take.
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			$display("timeout after %0d cycles", cycles);
			give_verdict();
		end
	end

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h6039_305a;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		density = 4'd0;
		num_errors = 0;
		num_checks = 0;
		cycles = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Power-on values, with one unmapped word after the four registers.
		for (int i = 0; i < 5; i++) apb(1'b0, 12'(i * 4), 32'h0000_0000);
		apb_idle();
		$display("test reset_values done");
		// All ones then zeros to every word, back to back; read-only bits must not move.
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 12'(i * 4), 32'hffff_ffff);
			apb(1'b0, 12'(i * 4), 32'h0000_0000);
			apb(1'b1, 12'(i * 4), 32'h0000_0000);
		end
		apb_idle();
		$display("test write_masks done");
		// Every source pulses every cycle, so a clearing write must lose to the events.
		density <= 4'd8;
		repeat (4) @(posedge pclk);
		apb(1'b1, `OFF_FLAGS_B, 32'h0000_0000);
		apb_idle();
		@(negedge pclk);
		check_word("flags_b", 32'h0000_00bf, 32'(flags.periph_flags_b));
		@(posedge pclk);
		$display("test set_beats_clear done");
		// Random traffic, a quarter of it to an unmapped word.
		density <= 4'd1;
		repeat (600) begin
			r = $random(seed);
			apb(r[4], (r[3] & r[2]) ? 12'h7f4 : {8'h00, r[1:0], 2'b00}, $random(seed));
			if (r[5]) apb_idle();
		end
		apb_idle();
		$display("test random_traffic done");
		// A second reset in mid-run clears everything at once.
		presetn <= 1'b0;
		@(negedge pclk);
		check_word("flags_in_reset", 32'h0000_0000, flags);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 4; i++) apb(1'b0, 12'(i * 4), 32'h0000_0000);
		apb_idle();
		$display("test second_reset done");
		give_verdict();
	end
endmodule

`default_nettype wire
